// File: pkg/sbst_pkg.sv
// sbst_pkg: constants, types and register map of the scan test port block
package sbst_pkg;

    // scan register sizes
    localparam int unsigned IR_W = 3;
    localparam int unsigned ID_W = 32;
    localparam int unsigned PIN_W = 108;
    localparam int unsigned BSR_W = 109;
    localparam int unsigned FLOAT_CELL = 108;
    localparam int unsigned JTAG_W = 3;

    // instruction encodings
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_IDCODE = 3'h1;
    localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
    localparam logic [2:0] IR_SAMPLE_PRELOAD = 3'h4;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    // pattern loaded into the instruction shift stage at capture
    localparam logic [2:0] IR_CAPTURE_PAT = 3'h1;

    // reset values
    localparam logic FLOAT_CELL_RST = 1'h1;
    localparam logic BYPASS_CAPTURE = 1'h0;

    // apb register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_IDCODE = 8'h08;
    localparam logic [7:0] REG_BSR0 = 8'h10;
    localparam logic [7:0] REG_BSR3 = 8'h1C;
    localparam int unsigned BSR_WORDS = 4;
    localparam int unsigned BSR_PAD = 19;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned WORD_IDX_LSB = 2;

    // control register fields
    localparam int unsigned CTRL_SOFT_RST_BIT = 0;
    localparam int unsigned CTRL_DRIVE_BIT = 1;
    localparam logic CTRL_DRIVE_RST = 1'h0;

    // tap controller states
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } sbst_tap_state_type;

    // serial test pins from the external controller
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } sbst_jtag_in_type;

    // status word as software reads it
    typedef struct packed {
        logic [19:0] zero;
        logic tdo_oe;
        logic pin_drive;
        logic q_oe;
        logic float_cell;
        logic [3:0] tap_state;
        logic zero_ir;
        logic [2:0] ir;
    } sbst_status_type;

endpackage

// File: logic/sbst_sync.sv
// sbst_sync: two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module sbst_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stable_ff;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            stable_ff <= '0;
        end else begin
            meta_ff <= async_in;
            stable_ff <= meta_ff;
        end
    end

    assign sync_out = stable_ff;
endmodule
`default_nettype wire

// File: logic/sbst_tap.sv
// sbst_tap: boundary-scan test access port with apb status and control
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// RQ1: capture fixed 32-bit id under idcode
// RQ2: id is constant, shifted out in shift-dr
// RQ3: three-bit instruction register, five functional codes
// RQ4: controller never loads reserved codes
// RQ5: shift-ir shifts through instruction register
// RQ6: new instruction effective only at update-ir
// RQ7: idcode selected at power-up and reset state
// RQ8: sample-z puts boundary register in chain
// RQ9: sample-z floats data bus until replaced
// RQ10: sample/preload captures all pins at capture-dr
// RQ11: test clock at most 20 MHz; the bench controller runs a 48 ns period, about 20.8 MHz
// RQ12: transitioning pins may capture any value
// RQ13: controller keeps pins stable around capture
// RQ14: captured boundary data shifts out in shift-dr
// RQ15: preload latches pattern onto cell outputs
// RQ16: shift-in and shift-out happen together
// RQ17: bypass puts one-bit register in chain
// RQ18: extest drives preloaded values onto pins
// RQ19: cell 108 latched at update-dr gates bus
// RQ20: one enables data drivers, zero floats them
// RQ21: float cell writable under sample/preload or extest
// RQ22: float cell preset to one at reset
// RQ23: capture-ir loads 01 into low bits
// RQ24: sample on tck rise, tdo on fall
// RQ25: instruction codes 000,001,010,100,111; rest reserved
// RQ26: serial in at msb, out at lsb
// RQ27: standard sixteen-state controller driven by tms
module sbst_tap #(
    parameter logic [31:0] IDCODE_VALUE = 32'h0ABC_D001, // arbitrary value, bit 0 marks id presence
    parameter int unsigned ADDR_W = 12
) (
    // system clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial test pins
    input wire sbst_pkg::sbst_jtag_in_type jtag_in,
    output logic tdo,
    output logic tdo_oe,
    // memory pins seen and driven by the boundary cells
    input wire logic [sbst_pkg::PIN_W-1:0] pin_sense,
    output logic [sbst_pkg::PIN_W-1:0] pin_drive_val,
    output logic pin_drive_en,
    output logic q_bus_oe
);
    // synchronised pins
    logic [sbst_pkg::JTAG_W+sbst_pkg::PIN_W-1:0] sync_vec;
    sbst_pkg::sbst_jtag_in_type jtag_s;
    logic [sbst_pkg::PIN_W-1:0] pin_s;
    logic tck_prev_ff;
    logic tck_rise;
    logic tck_fall;

    // tap state
    sbst_pkg::sbst_tap_state_type state_ff;
    sbst_pkg::sbst_tap_state_type nxt_state;
    logic [sbst_pkg::IR_W-1:0] ir_shift_ff;
    logic [sbst_pkg::IR_W-1:0] ir_ff;
    logic bypass_ff;
    logic [sbst_pkg::ID_W-1:0] id_shift_ff;
    logic [sbst_pkg::BSR_W-1:0] bsr_shift_ff;
    logic [sbst_pkg::BSR_W-1:0] bsr_upd_ff;
    logic tdo_ff;
    logic tdo_oe_ff;
    logic nxt_tdo;
    logic pin_drive_en_ff;
    logic q_bus_oe_ff;
    logic nxt_q_bus_oe;
    logic bsr_selected;

    // apb state
    logic ctrl_drive_ff;
    logic soft_rst_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] nxt_rdata;
    logic nxt_err;
    logic apb_access;
    logic apb_write;
    logic [7:0] reg_addr;
    sbst_pkg::sbst_status_type status;

    // standard tap state transition on one tms sample
    function automatic sbst_pkg::sbst_tap_state_type tap_next(
        input sbst_pkg::sbst_tap_state_type cur,
        input logic tms
    );
        sbst_pkg::sbst_tap_state_type nxt;
        nxt = cur;
        unique case (cur)
            sbst_pkg::TLR: nxt = tms ? sbst_pkg::TLR : sbst_pkg::RTI;
            sbst_pkg::RTI: nxt = tms ? sbst_pkg::SEL_DR : sbst_pkg::RTI;
            sbst_pkg::SEL_DR: nxt = tms ? sbst_pkg::SEL_IR : sbst_pkg::CAP_DR;
            sbst_pkg::CAP_DR: nxt = tms ? sbst_pkg::EX1_DR : sbst_pkg::SHF_DR;
            sbst_pkg::SHF_DR: nxt = tms ? sbst_pkg::EX1_DR : sbst_pkg::SHF_DR;
            sbst_pkg::EX1_DR: nxt = tms ? sbst_pkg::UPD_DR : sbst_pkg::PAU_DR;
            sbst_pkg::PAU_DR: nxt = tms ? sbst_pkg::EX2_DR : sbst_pkg::PAU_DR;
            sbst_pkg::EX2_DR: nxt = tms ? sbst_pkg::UPD_DR : sbst_pkg::SHF_DR;
            sbst_pkg::UPD_DR: nxt = tms ? sbst_pkg::SEL_DR : sbst_pkg::RTI;
            sbst_pkg::SEL_IR: nxt = tms ? sbst_pkg::TLR : sbst_pkg::CAP_IR;
            sbst_pkg::CAP_IR: nxt = tms ? sbst_pkg::EX1_IR : sbst_pkg::SHF_IR;
            sbst_pkg::SHF_IR: nxt = tms ? sbst_pkg::EX1_IR : sbst_pkg::SHF_IR;
            sbst_pkg::EX1_IR: nxt = tms ? sbst_pkg::UPD_IR : sbst_pkg::PAU_IR;
            sbst_pkg::PAU_IR: nxt = tms ? sbst_pkg::EX2_IR : sbst_pkg::PAU_IR;
            sbst_pkg::EX2_IR: nxt = tms ? sbst_pkg::UPD_IR : sbst_pkg::SHF_IR;
            sbst_pkg::UPD_IR: nxt = tms ? sbst_pkg::SEL_DR : sbst_pkg::RTI;
        endcase
        return nxt;
    endfunction

    // true when the instruction routes the boundary register
    function automatic logic uses_bsr(input logic [sbst_pkg::IR_W-1:0] code);
        return (code == sbst_pkg::IR_EXTEST) || (code == sbst_pkg::IR_SAMPLE_Z)
            || (code == sbst_pkg::IR_SAMPLE_PRELOAD); // RQ25
    endfunction

    // one word of the latched boundary stage, upper bits zero
    function automatic logic [31:0] bsr_word(
        input logic [sbst_pkg::BSR_W-1:0] vec,
        input logic [1:0] idx
    );
        logic [sbst_pkg::BSR_W+sbst_pkg::BSR_PAD-1:0] padded;
        padded = {{sbst_pkg::BSR_PAD{1'b0}}, vec};
        return padded[idx*sbst_pkg::WORD_W +: sbst_pkg::WORD_W];
    endfunction

    // test pins and memory pins are asynchronous to pclk
    sbst_sync #(
        .WIDTH(sbst_pkg::JTAG_W + sbst_pkg::PIN_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({jtag_in, pin_sense}),
        .sync_out(sync_vec)
    );

    assign jtag_s = sync_vec[sbst_pkg::JTAG_W+sbst_pkg::PIN_W-1:sbst_pkg::PIN_W];
    assign pin_s = sync_vec[sbst_pkg::PIN_W-1:0];

    // test clock edge detection on the synchronised level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tck_prev_ff <= 1'b0;
        end else begin
            tck_prev_ff <= jtag_s.tck;
        end
    end

    assign tck_rise = jtag_s.tck & ~tck_prev_ff; // RQ24
    assign tck_fall = ~jtag_s.tck & tck_prev_ff; // RQ24

    // controller state, advanced by tms at each test clock rise
    always_comb begin
        nxt_state = state_ff;
        if (soft_rst_ff) begin
            nxt_state = sbst_pkg::TLR;
        end else if (tck_rise) begin
            nxt_state = tap_next(state_ff, jtag_s.tms); // RQ27
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= sbst_pkg::TLR;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // instruction shift stage and current instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_shift_ff <= sbst_pkg::IR_CAPTURE_PAT;
            ir_ff <= sbst_pkg::IR_IDCODE; // RQ7
        end else if (state_ff == sbst_pkg::TLR) begin
            ir_ff <= sbst_pkg::IR_IDCODE; // RQ7
        end else if (tck_rise) begin
            unique case (state_ff)
                sbst_pkg::CAP_IR: ir_shift_ff <= sbst_pkg::IR_CAPTURE_PAT; // RQ23
                sbst_pkg::SHF_IR: ir_shift_ff <= {jtag_s.tdi, ir_shift_ff[sbst_pkg::IR_W-1:1]}; // RQ5 RQ26
                sbst_pkg::UPD_IR: ir_ff <= ir_shift_ff; // RQ6 RQ3
                default: ir_shift_ff <= ir_shift_ff;
            endcase
        end
    end

    // bypass and identification data registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bypass_ff <= sbst_pkg::BYPASS_CAPTURE;
            id_shift_ff <= IDCODE_VALUE;
        end else if (tck_rise) begin
            if (state_ff == sbst_pkg::CAP_DR) begin
                bypass_ff <= sbst_pkg::BYPASS_CAPTURE;
                if (ir_ff == sbst_pkg::IR_IDCODE) begin
                    id_shift_ff <= IDCODE_VALUE; // RQ1 RQ2
                end
            end else if (state_ff == sbst_pkg::SHF_DR) begin
                bypass_ff <= jtag_s.tdi; // RQ17
                if (ir_ff == sbst_pkg::IR_IDCODE) begin
                    id_shift_ff <= {jtag_s.tdi, id_shift_ff[sbst_pkg::ID_W-1:1]}; // RQ2 RQ26
                end
            end
        end
    end

    // boundary shift stage: capture pins, shift through tdi/tdo
    // a pin moving near the capture edge may be caught either way
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bsr_shift_ff <= '0;
        end else if (tck_rise && uses_bsr(ir_ff)) begin
            if (state_ff == sbst_pkg::CAP_DR) begin
                bsr_shift_ff <= {bsr_upd_ff[sbst_pkg::FLOAT_CELL], pin_s}; // RQ10 RQ12
            end else if (state_ff == sbst_pkg::SHF_DR) begin
                bsr_shift_ff <= {jtag_s.tdi, bsr_shift_ff[sbst_pkg::BSR_W-1:1]}; // RQ8 RQ14 RQ16 RQ21
            end
        end
    end

    // boundary latched stage, with the float cell preset in reset state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bsr_upd_ff <= '0;
            bsr_upd_ff[sbst_pkg::FLOAT_CELL] <= sbst_pkg::FLOAT_CELL_RST; // RQ22
        end else if (state_ff == sbst_pkg::TLR) begin
            bsr_upd_ff[sbst_pkg::FLOAT_CELL] <= sbst_pkg::FLOAT_CELL_RST; // RQ22
        end else if (tck_rise && state_ff == sbst_pkg::UPD_DR && uses_bsr(ir_ff)) begin
            bsr_upd_ff <= bsr_shift_ff; // RQ15 RQ19
        end
    end

    // serial output source for the current path
    assign bsr_selected = uses_bsr(ir_ff);
    always_comb begin
        nxt_tdo = bypass_ff;
        if (state_ff == sbst_pkg::SHF_IR) begin
            nxt_tdo = ir_shift_ff[0]; // RQ5
        end else if (ir_ff == sbst_pkg::IR_IDCODE) begin
            nxt_tdo = id_shift_ff[0]; // RQ2
        end else if (bsr_selected) begin
            nxt_tdo = bsr_shift_ff[0]; // RQ14
        end
    end

    // tdo changes only on the falling test clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdo_ff <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else if (tck_fall) begin
            tdo_ff <= nxt_tdo; // RQ24
            tdo_oe_ff <= (state_ff == sbst_pkg::SHF_IR) || (state_ff == sbst_pkg::SHF_DR);
        end
    end

    // output data bus enable: sample-z floats, extest obeys the float cell
    always_comb begin
        nxt_q_bus_oe = ctrl_drive_ff;
        if (ir_ff == sbst_pkg::IR_SAMPLE_Z) begin
            nxt_q_bus_oe = 1'b0; // RQ9
        end else if (ir_ff == sbst_pkg::IR_EXTEST) begin
            nxt_q_bus_oe = bsr_upd_ff[sbst_pkg::FLOAT_CELL]; // RQ19 RQ20
        end
    end

    // pin drive stage registered so outputs come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_bus_oe_ff <= 1'b0;
            pin_drive_en_ff <= 1'b0;
        end else begin
            q_bus_oe_ff <= nxt_q_bus_oe;
            pin_drive_en_ff <= (ir_ff == sbst_pkg::IR_EXTEST); // RQ18
        end
    end

    // apb decode
    assign apb_access = psel & penable & ~pready_ff;
    assign apb_write = psel & penable & pready_ff & pwrite & ~pslverr_ff;
    assign reg_addr = paddr[7:0];

    // status view of the tap
    always_comb begin
        status = '0;
        status.ir = ir_ff;
        status.tap_state = state_ff;
        status.float_cell = bsr_upd_ff[sbst_pkg::FLOAT_CELL];
        status.q_oe = q_bus_oe_ff;
        status.pin_drive = pin_drive_en_ff;
        status.tdo_oe = tdo_oe_ff;
    end

    // read mux; upper address bits must be zero for a hit
    always_comb begin
        nxt_rdata = '0;
        nxt_err = 1'b0;
        if (paddr[ADDR_W-1:8] != '0) begin
            nxt_err = 1'b1;
        end else if (reg_addr == sbst_pkg::REG_STATUS) begin
            nxt_rdata = status;
            nxt_err = pwrite;
        end else if (reg_addr == sbst_pkg::REG_CTRL) begin
            nxt_rdata[sbst_pkg::CTRL_DRIVE_BIT] = ctrl_drive_ff;
        end else if (reg_addr == sbst_pkg::REG_IDCODE) begin
            nxt_rdata = IDCODE_VALUE;
            nxt_err = pwrite;
        end else if (reg_addr >= sbst_pkg::REG_BSR0 && reg_addr <= sbst_pkg::REG_BSR3
            && reg_addr[1:0] == 2'h0) begin
            nxt_rdata = bsr_word(bsr_upd_ff, reg_addr[sbst_pkg::WORD_IDX_LSB +: 2]);
            nxt_err = pwrite;
        end else begin
            nxt_err = 1'b1;
        end
    end

    // one wait state: answer on the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            pready_ff <= apb_access;
            pslverr_ff <= apb_access & nxt_err;
            prdata_ff <= (apb_access && !pwrite) ? nxt_rdata : '0;
        end
    end

    // control register; soft reset is a self-clearing pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_drive_ff <= sbst_pkg::CTRL_DRIVE_RST;
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= 1'b0;
            if (apb_write && reg_addr == sbst_pkg::REG_CTRL && pstrb[0]) begin
                ctrl_drive_ff <= pwdata[sbst_pkg::CTRL_DRIVE_BIT];
                soft_rst_ff <= pwdata[sbst_pkg::CTRL_SOFT_RST_BIT];
            end
        end
    end

    // outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign tdo = tdo_ff;
    assign tdo_oe = tdo_oe_ff;
    assign pin_drive_val = bsr_upd_ff[sbst_pkg::PIN_W-1:0]; // RQ18
    assign pin_drive_en = pin_drive_en_ff;
    assign q_bus_oe = q_bus_oe_ff; // RQ9 RQ20
endmodule
`default_nettype wire

// File: testbench/sbst_tap_sva.sv
// sbst_tap_sva: port-level checks for the scan test port
`timescale 1ns/100ps
`default_nettype none
module sbst_tap_sva #(
    parameter logic [31:0] IDCODE_VALUE = 32'h0ABC_D001, // arbitrary value
    parameter int unsigned ADDR_W = 12
) (
    // system clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // serial test pins
    input wire sbst_pkg::sbst_jtag_in_type jtag_in,
    input wire logic tdo,
    input wire logic tdo_oe,
    // memory pins
    input wire logic [sbst_pkg::PIN_W-1:0] pin_sense,
    input wire logic [sbst_pkg::PIN_W-1:0] pin_drive_val,
    input wire logic pin_drive_en,
    input wire logic q_bus_oe
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // a finished status read; the scan clock idles during reads, so fields are settled
    logic st_rd;
    sbst_pkg::sbst_status_type st;
    assign st_rd = psel && penable && pready && !pwrite && paddr == '0;
    assign st = prdata;

    // access phase taken, then a one-cycle answer
    sequence s_take;
        psel && penable && !pready;
    endsequence
    sequence s_done;
        pready ##1 !pready;
    endsequence

    AST_APB_ANSWER: assert property (s_take |=> s_done)
        else $error("apb answer not one cycle after the access phase");
    AST_APB_RO: assert property (pready && pwrite && (paddr == '0 || paddr == 'h8) |-> pslverr)
        else $error("write to read-only register not refused");
    AST_ID_REG: assert property (pready && !pwrite && paddr == 'h8 |-> prdata == IDCODE_VALUE && !pslverr)
        else $error("id register not the fixed code");
    AST_EXT_DRIVE: assert property (st_rd |-> st.pin_drive == (st.ir == sbst_pkg::IR_EXTEST))
        else $error("pin drive not tied to external test");
    AST_Z_FLOAT: assert property (st_rd && st.ir == sbst_pkg::IR_SAMPLE_Z |-> !st.q_oe && !q_bus_oe)
        else $error("data bus driven under sample with float");
    AST_CELL_GATE: assert property (st_rd && st.ir == sbst_pkg::IR_EXTEST |-> st.q_oe == st.float_cell)
        else $error("data bus enable differs from float cell");
    AST_TLR_INIT: assert property (st_rd && st.tap_state == 4'h0 |-> st.ir == sbst_pkg::IR_IDCODE && st.float_cell)
        else $error("reset state without id instruction or float cell");
    AST_TDO_FALL: assert property ($changed(tdo) |-> !$past(jtag_in.tck) && !$past(jtag_in.tck, 2))
        else $error("tdo moved while tck high");
    AST_TDO_HOLD: assert property (jtag_in.tck [*5] |-> $stable(tdo))
        else $error("tdo moved during tck high phase");
endmodule

bind sbst_tap sbst_tap_sva #(.IDCODE_VALUE(IDCODE_VALUE), .ADDR_W(ADDR_W)) u_sbst_tap_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .jtag_in(jtag_in), .tdo(tdo), .tdo_oe(tdo_oe), .pin_sense(pin_sense),
    .pin_drive_val(pin_drive_val), .pin_drive_en(pin_drive_en), .q_bus_oe(q_bus_oe)
);
`default_nettype wire

// File: testbench/sbst_jtag_ctl.sv
// sbst_jtag_ctl: behavioural external scan controller
`timescale 1ns/100ps
`default_nettype none
module sbst_jtag_ctl (
    // scan pins
    output var sbst_pkg::sbst_jtag_in_type jtag_in,
    input wire logic tdo
);
    // tck rests low between frames; tdi idles high like its pull-up
    initial jtag_in = 3'h1;

    // one 48 ns tck period, about 20.8 MHz, just over the 20 MHz ceiling; tdo read just before the rise
    task automatic step(input logic m, input logic d, output logic o);
        jtag_in.tms = m;
        jtag_in.tdi = d;
        #24;
        o = tdo;
        jtag_in.tck = 1'h1;
        #24;
        jtag_in.tck = 1'h0;
    endtask

    // five tms highs reach the reset state, then park in run-test/idle
    task automatic tlr();
        logic o;
        #1.3;
        for (int i = 0; i < 5; i++) step(1'h1, 1'h1, o);
        step(1'h0, 1'h1, o);
    endtask

    // ir or dr scan from idle; bit i of dout is the i-th bit seen
    task automatic scan(input logic is_ir, input int n, input logic [108:0] din,
                        output logic [108:0] dout);
        logic o;
        #1.3;
        dout = '0;
        step(1'h1, 1'h1, o);
        if (is_ir) step(1'h1, 1'h1, o);
        step(1'h0, 1'h1, o);
        step(1'h0, 1'h1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        // update is always passed, so a loaded code takes hold
        step(1'h1, 1'h1, o);
        step(1'h0, 1'h1, o);
    endtask
endmodule
`default_nettype wire

// File: testbench/test_sram_boundary_scan_tap_instructions.sv
// test_sram_boundary_scan_tap_instructions: self-checking bench of the scan port
`timescale 1ns/100ps
`default_nettype none
module test_sram_boundary_scan_tap_instructions;
    localparam logic [31:0] ID_VAL = 32'h0ABC_D001; // arbitrary value
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tdo, tdo_oe, pin_drive_en, q_bus_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [107:0] pin_sense, pin_drive_val, mdl_lat;
    logic [108:0] din, dout;
    logic [127:0] r;
    logic [2:0] mdl_ir;
    logic mdl_cell, mdl_drv, err;
    int miscompares, n_tests, seed;
    // working codes only; reserved ones are never sent
    logic [2:0] codes[$] = '{3'h1, 3'h7, 3'h4, 3'h0, 3'h2};
    sbst_pkg::sbst_jtag_in_type jtag_in;

    sbst_tap #(.IDCODE_VALUE(ID_VAL), .ADDR_W(12)) u_sbst_tap (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .jtag_in(jtag_in), .tdo(tdo), .tdo_oe(tdo_oe), .pin_sense(pin_sense),
        .pin_drive_val(pin_drive_val), .pin_drive_en(pin_drive_en), .q_bus_oe(q_bus_oe)
    );
    sbst_jtag_ctl u_sbst_jtag_ctl (.jtag_in(jtag_in), .tdo(tdo));

    // 250 MHz system clock
    initial begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end

    task automatic chk_vec(input string nm, input logic [108:0] e, input logic [108:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // apb transfer entered just after an edge; waits for pready, bounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rv, output logic e);
        int k;
        k = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {4'h0, a};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1 && k < 50) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 50) miscompares++;
        rv = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic rnd(output logic [127:0] v);
        v = {$random(seed), $random(seed), $random(seed), $random(seed)};
    endtask

    // status and live enables against the model; sampling waits out the tdo update
    task automatic st_check(input logic [3:0] s);
        logic pd, qo;
        pd = mdl_ir == 3'h0;
        qo = mdl_ir == 3'h2 ? 1'h0 : pd ? mdl_cell : mdl_drv;
        repeat (6) @(posedge pclk);
        apb(1'h0, 8'h00, 32'h0, rd, err);
        chk_word("status", {21'h0, pd, qo, mdl_cell, s, 1'h0, mdl_ir}, rd);
        chk_word("oe pins", {30'h0, pd, qo}, {30'h0, pin_drive_en, q_bus_oe});
    endtask

    // load one code, then two data scans on the path it selects
    task automatic round(input logic [2:0] c);
        int n;
        u_sbst_jtag_ctl.scan(1'h1, 3, {106'h0, c}, dout);
        chk_vec("ir capture", 109'h1, dout);
        mdl_ir = c;
        n = c == 3'h1 ? 32 : c == 3'h7 ? 8 : 109;
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            rnd(r);
            pin_sense <= r[107:0];
            rnd(r);
            din = r[108:0];
            din[108] = ~k[0]; // float cell set, then cleared
            u_sbst_jtag_ctl.scan(1'h0, n, din, dout);
            case (c)
                3'h1: chk_vec("id out", {77'h0, ID_VAL}, dout);
                3'h7: chk_vec("bypass out", {101'h0, din[6:0], 1'h0}, dout);
                default: begin
                    chk_vec("bsr out", {mdl_cell, pin_sense}, dout);
                    mdl_cell = din[108];
                    mdl_lat = din[107:0];
                end
            endcase
            st_check(4'h1);
            if (n == 109) chk_vec("latched", {1'h0, mdl_lat}, {1'h0, pin_drive_val});
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // cut a hang short
    initial begin
        #300000;
        miscompares++;
        wrap_up();
    end

    // reset, register access, every instruction, soft and tms resets
    initial begin
        seed = 32'h606cb853;
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        pin_sense = '0;
        mdl_ir = 3'h1;
        mdl_cell = 1'h1;
        mdl_drv = 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, 8'h08, 32'h0, rd, err);
        chk_word("idcode reg", ID_VAL, rd);
        apb(1'h1, 8'h00, 32'hFFFF_FFFF, rd, err);
        chk_word("ro write err", 32'h1, {31'h0, err});
        apb(1'h0, 8'h0C, 32'h0, rd, err);
        chk_word("unmapped err", 32'h1, {31'h0, err});
        apb(1'h1, 8'h04, 32'h2, rd, err);
        mdl_drv = 1'h1;
        apb(1'h0, 8'h04, 32'h0, rd, err);
        chk_word("ctrl", 32'h2, rd);
        st_check(4'h0);
        u_sbst_jtag_ctl.tlr();
        foreach (codes[i]) round(codes[i]);
        apb(1'h0, 8'h10, 32'h0, rd, err);
        chk_word("bsr word", mdl_lat[31:0], rd);
        apb(1'h1, 8'h04, 32'h3, rd, err);
        mdl_ir = 3'h1;
        mdl_cell = 1'h1;
        st_check(4'h0);
        u_sbst_jtag_ctl.tlr();
        round(3'h0);
        u_sbst_jtag_ctl.tlr();
        mdl_ir = 3'h1;
        mdl_cell = 1'h1;
        st_check(4'h1);
        wrap_up();
    end
endmodule
`default_nettype wire
